// >>> core/lpddr_cmd_bank.sv
// command decoder, per-bank state tracker and power state of a four-bank memory
// assumes all pins are synchronous to clk (rising edge of the true clock)
`timescale 1ns/1ps

module lpddr_cmd_bank
    import lpddr_cmd_pkg::*;
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // command pins
    input  wire logic                 chip_sel_n,
    input  wire logic                 row_strobe_n,
    input  wire logic                 col_strobe_n,
    input  wire logic                 write_en_n,
    input  wire logic                 clock_enable_now,
    input  wire logic                 bank_select_bit0,
    input  wire logic                 bank_select_bit1,
    input  wire logic [ADDR_W-1:0]    addr,
    input  wire logic                 write_mask,
    input  wire logic                 write_beat,
    // bank and burst status
    output logic [4*NUM_BANKS-1:0]    bank_state,
    output logic [ADDR_W-1:0]         col_addr,
    output logic [BANK_W-1:0]         burst_bank,
    output logic                      auto_close_row,
    output logic                      beat_store,
    // mode register contents
    output logic [ADDR_W-1:0]         mode_reg,
    output logic [ADDR_W-1:0]         ext_mode_reg,
    output logic                      status_reg_read,
    // power and refresh status
    output logic [4:0]                power_state,
    output logic                      exit_busy,
    output logic [BANK_W-1:0]         refresh_bank,
    output logic                      refresh_pulse
);

    // ------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------
    // pin pattern decode
    function automatic cmd_e decode(input logic cs_n, input logic ras_n, input logic cas_n, input logic we_n);
        cmd_e c;
        c = CMD_NOP;
        if (cs_n) begin
            c = CMD_DESEL;
        end else begin
            case ({ras_n, cas_n, we_n})
                3'h3:    c = CMD_ACT;
                3'h5:    c = CMD_RD;
                3'h4:    c = CMD_WR;
                3'h2:    c = CMD_PRE;   // precharge pattern
                3'h1:    c = CMD_REF;
                3'h0:    c = CMD_MRS;
                3'h6:    c = CMD_BST;
                default: c = CMD_NOP;   // all-high is no-op
            endcase
        end
        return c;
    endfunction : decode

    logic [BANK_W-1:0] bank_addr;
    cmd_e              cmd;
    logic              is_nop;
    assign bank_addr = {bank_select_bit1, bank_select_bit0};
    assign cmd       = decode(chip_sel_n, row_strobe_n, col_strobe_n, write_en_n);
    assign is_nop    = (cmd == CMD_NOP) || (cmd == CMD_DESEL);

    // ------------------------------------------------------------
    // clock enable history and power state
    // ------------------------------------------------------------
    logic              clock_enable_prev_q, clock_enable_prev_d;
    pwr_e              pwr_q, pwr_d;
    logic [EXIT_W-1:0] exit_cnt_q, exit_cnt_d;
    logic              all_idle;
    logic              cmd_ok;
    bank_e             bank_q [NUM_BANKS], bank_d [NUM_BANKS];

    // all banks idle is the precharge power down condition
    always_comb begin
        all_idle = 1'b1;
        for (int i = 0; i < NUM_BANKS; i++) begin
            if (bank_q[i] != BANK_IDLE) begin
                all_idle = 1'b0;
            end
        end
    end

    // bank rules only with enable high twice and exit done
    assign cmd_ok = clock_enable_prev_q && clock_enable_now && (exit_cnt_q == '0) && (pwr_q == PWR_ON);

    // power transitions from enable history
    always_comb begin
        pwr_d               = pwr_q;
        exit_cnt_d          = exit_cnt_q;
        clock_enable_prev_d = clock_enable_now;
        if (exit_cnt_q != '0) begin
            exit_cnt_d = exit_cnt_q - 1'b1;
        end
        case (pwr_q)
            PWR_ON: begin
                if (clock_enable_prev_q && !clock_enable_now && exit_cnt_q == '0) begin
                    if (is_nop) begin
                        pwr_d = all_idle ? PWR_PRE_PD : PWR_ACT_PD;
                    end else if (cmd == CMD_REF) begin
                        pwr_d = PWR_SELF;
                    end else if (cmd == CMD_BST) begin
                        pwr_d = PWR_DEEP;
                    end
                end
            end
            default: begin
                // hold while low, exit on rising with nop
                if (!clock_enable_prev_q && clock_enable_now && is_nop) begin
                    pwr_d = PWR_ON;
                    if (pwr_q == PWR_SELF) begin
                        exit_cnt_d = EXIT_W'(SR_EXIT_CYC);
                    end else if (pwr_q != PWR_DEEP) begin
                        exit_cnt_d = EXIT_W'(PD_EXIT_CYC);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clock_enable_prev_q <= 1'b0;
            pwr_q               <= PWR_ON;
            exit_cnt_q          <= '0;
        end else begin
            clock_enable_prev_q <= clock_enable_prev_d;
            pwr_q               <= pwr_d;
            exit_cnt_q          <= exit_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // per-bank state
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] col_q, col_d;
    logic [BANK_W-1:0] bb_q, bb_d;
    logic              ap_q, ap_d;
    logic [ADDR_W-1:0] mr_q, mr_d, emr_q, emr_d;
    logic              srr_q, srr_d;
    logic [BANK_W-1:0] ref_cnt_q, ref_cnt_d;
    logic              ref_p_q, ref_p_d;

    always_comb begin
        bank_d    = bank_q;
        col_d     = col_q;
        bb_d      = bb_q;
        ap_d      = ap_q;
        mr_d      = mr_q;
        emr_d     = emr_q;
        srr_d     = srr_q;
        ref_cnt_d = ref_cnt_q;
        ref_p_d   = 1'b0;
        if (cmd_ok) begin
            case (cmd)
                CMD_ACT: begin
                    if (bank_q[bank_addr] == BANK_IDLE) begin
                        bank_d[bank_addr] = BANK_ACTIVE;
                    end
                end
                CMD_RD, CMD_WR: begin
                    // open or bursting bank starts new burst
                    if (bank_q[bank_addr] != BANK_IDLE || srr_q) begin
                        col_d = addr;
                        bb_d  = bank_addr;
                        ap_d  = addr[AP_BIT];
                        if (srr_q) begin
                            srr_d = 1'b0;
                        end else if (addr[AP_BIT]) begin
                            // auto precharge burst returns bank to idle as burst is not modelled in length
                            bank_d[bank_addr] = BANK_IDLE;
                        end else begin
                            bank_d[bank_addr] = (cmd == CMD_RD) ? BANK_READ : BANK_WRITE;
                        end
                    end
                end
                CMD_PRE: begin
                    if (addr[AP_BIT]) begin
                        for (int i = 0; i < NUM_BANKS; i++) begin
                            bank_d[i] = BANK_IDLE;
                        end
                    end else begin
                        bank_d[bank_addr] = BANK_IDLE;
                    end
                end
                CMD_BST: begin
                    if (bank_q[bb_q] == BANK_READ) begin
                        bank_d[bb_q] = BANK_ACTIVE;
                    end
                end
                CMD_REF: begin
                    if (all_idle) begin
                        ref_cnt_d = ref_cnt_q + 1'b1;
                        ref_p_d   = 1'b1;
                    end
                end
                CMD_MRS: begin
                    if (all_idle) begin
                        if (bank_addr == MRS_TGT_MODE) begin
                            mr_d = addr;
                        end else if (bank_addr == MRS_TGT_EXT) begin
                            emr_d = addr;
                        end else if (bank_addr == MRS_TGT_STATUS) begin
                            srr_d = 1'b1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_BANKS; i++) begin
                bank_q[i] <= BANK_IDLE;
            end
            col_q     <= '0;
            bb_q      <= '0;
            ap_q      <= 1'b0;
            mr_q      <= '0;
            emr_q     <= '0;
            srr_q     <= 1'b0;
            ref_cnt_q <= '0;
            ref_p_q   <= 1'b0;
        end else begin
            bank_q    <= bank_d;
            col_q     <= col_d;
            bb_q      <= bb_d;
            ap_q      <= ap_d;
            mr_q      <= mr_d;
            emr_q     <= emr_d;
            srr_q     <= srr_d;
            ref_cnt_q <= ref_cnt_d;
            ref_p_q   <= ref_p_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < NUM_BANKS; g++) begin : g_state
            assign bank_state[4*g +: 4] = bank_q[g];
        end
    endgenerate
    assign beat_store      = write_beat && !write_mask && (bank_q[bb_q] == BANK_WRITE);
    assign col_addr        = col_q;
    assign burst_bank      = bb_q;
    assign auto_close_row  = ap_q;
    assign mode_reg        = mr_q;
    assign ext_mode_reg    = emr_q;
    assign status_reg_read = srr_q;
    assign power_state     = pwr_q;
    assign exit_busy       = (exit_cnt_q != '0);
    assign refresh_bank    = ref_cnt_q;
    assign refresh_pulse   = ref_p_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_pd_entry: assert property (@(posedge clk) disable iff (rst)
        (pwr_q == PWR_ON && clock_enable_prev_q && !clock_enable_now && exit_cnt_q == '0 && is_nop && all_idle)
        |=> (pwr_q == PWR_PRE_PD))
        else $error("precharge power down not entered");
    chk_self_entry: assert property (@(posedge clk) disable iff (rst)
        (pwr_q == PWR_ON && clock_enable_prev_q && !clock_enable_now && exit_cnt_q == '0 && cmd == CMD_REF)
        |=> (pwr_q == PWR_SELF))
        else $error("self refresh not entered");
    chk_deep_entry: assert property (@(posedge clk) disable iff (rst)
        (pwr_q == PWR_ON && clock_enable_prev_q && !clock_enable_now && exit_cnt_q == '0 && cmd == CMD_BST)
        |=> (pwr_q == PWR_DEEP))
        else $error("deep power down not entered");
    chk_pd_hold: assert property (@(posedge clk) disable iff (rst)
        (pwr_q != PWR_ON && !clock_enable_prev_q && !clock_enable_now) |=> $stable(pwr_q))
        else $error("low power state not held");
    chk_sr_exit: assert property (@(posedge clk) disable iff (rst)
        (pwr_q == PWR_SELF && pwr_d == PWR_ON) |=> exit_busy [*8] ##1 exit_busy [*4] ##1 !exit_busy)
        else $error("self refresh exit time wrong");
    chk_pre_all: assert property (@(posedge clk) disable iff (rst)
        (cmd_ok && cmd == CMD_PRE && addr[AP_BIT]) |=> all_idle)
        else $error("precharge all left a bank open");
    chk_act_bank: assert property (@(posedge clk) disable iff (rst)
        (cmd_ok && cmd == CMD_ACT && bank_q[bank_addr] == BANK_IDLE) |=> bank_q[$past(bank_addr)] == BANK_ACTIVE)
        else $error("activate did not open row");
    chk_rd_burst: assert property (@(posedge clk) disable iff (rst)
        (cmd_ok && cmd == CMD_RD && !srr_q && !addr[AP_BIT] && bank_q[bank_addr] != BANK_IDLE)
        |=> (bank_q[bb_q] == BANK_READ && col_addr == $past(addr)))
        else $error("read burst not started");
    chk_mask: assert property (@(posedge clk) disable iff (rst)
        write_mask |-> !beat_store)
        else $error("masked beat stored");

endmodule : lpddr_cmd_bank

// >>> core/lpddr_cmd_pkg.sv
// constants shared by the command decode and bank state logic
// assumes a single 100 MHz clock domain; no bus, all bits are ports
package lpddr_cmd_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int NUM_BANKS  = 4;
    localparam int ADDR_W     = 13;
    localparam int BANK_W     = 2;
    localparam int BURST_W    = 4;

    // ------------------------------------------------------------
    // address field positions
    // ------------------------------------------------------------
    localparam int AP_BIT     = 10;

    // ------------------------------------------------------------
    // mode register set targets (bank select value)
    // ------------------------------------------------------------
    localparam logic [1:0] MRS_TGT_MODE   = 2'h0;
    localparam logic [1:0] MRS_TGT_STATUS = 2'h1;
    localparam logic [1:0] MRS_TGT_EXT    = 2'h2;

    // ------------------------------------------------------------
    // reset values and timing counts
    // ------------------------------------------------------------
    localparam logic [BURST_W-1:0] BURST_LEN_RST = 4'h4;
    localparam int CLK_PERIOD_NS              = 10;
    localparam int POWER_DOWN_EXIT_TIME_NS    = 20;
    localparam int SELF_REFRESH_EXIT_TIME_NS  = 120;
    localparam int PD_EXIT_CYC = (POWER_DOWN_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SR_EXIT_CYC = (SELF_REFRESH_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXIT_W      = 8;

    // ------------------------------------------------------------
    // decoded commands
    // ------------------------------------------------------------
    typedef enum logic [8:0] {
        CMD_NOP     = 9'h001,
        CMD_ACT     = 9'h002,
        CMD_RD      = 9'h004,
        CMD_WR      = 9'h008,
        CMD_BST     = 9'h010,
        CMD_PRE     = 9'h020,
        CMD_REF     = 9'h040,
        CMD_MRS     = 9'h080,
        CMD_DESEL   = 9'h100
    } cmd_e;

    // per-bank state
    typedef enum logic [3:0] {
        BANK_IDLE   = 4'h1,
        BANK_ACTIVE = 4'h2,
        BANK_READ   = 4'h4,
        BANK_WRITE  = 4'h8
    } bank_e;

    // device power state
    typedef enum logic [4:0] {
        PWR_ON      = 5'h01,
        PWR_PRE_PD  = 5'h02,
        PWR_ACT_PD  = 5'h04,
        PWR_SELF    = 5'h08,
        PWR_DEEP    = 5'h10
    } pwr_e;

endpackage : lpddr_cmd_pkg

// >>> verification/lpddr_command_decode_and_bank_state_tb.sv
// bench: behavioural model of the bank and power state, compared every cycle
// assumes one 100 MHz clock; the host model drives all memory pins
`timescale 1ns/1ps
module lpddr_command_decode_and_bank_state_tb
    import lpddr_cmd_pkg::*;
;
    typedef struct packed {
        logic [3:0][3:0]   st;
        logic [4:0]        pw;
        logic [7:0]        cnt;
        logic              pcke, stat, known, pulse, ap;
        logic [ADDR_W-1:0] col, mr, emr;
        logic [1:0]        bb, rb;
    } model_s;

    logic clk, rst, req_cke, req_mask, req_beat, all_idle, nopish, busy, ok;
    logic cs_n, ras_n, cas_n, we_n, cke, ba0, ba1, mask, beat;
    logic auto_close_row, beat_store, status_reg_read, exit_busy, refresh_pulse;
    logic [15:0] bank_state;
    logic [ADDR_W-1:0] req_addr, noise, addr, col_addr, mode_reg, ext_mode_reg;
    logic [1:0] req_bank, burst_bank, refresh_bank, b;
    logic [4:0] power_state;
    logic [31:0] rnd;
    cmd_e req_cmd, c;
    model_s m;
    int errors, compares;
    cmd_e pick [8] = '{CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_BST, CMD_NOP, CMD_DESEL, CMD_RD};

    lpddr_host_model lpddr_host_model_i (.req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
        .req_cke(req_cke), .req_mask(req_mask), .req_beat(req_beat), .noise(noise), .chip_sel_n(cs_n),
        .row_strobe_n(ras_n), .col_strobe_n(cas_n), .write_en_n(we_n), .clock_enable_now(cke),
        .bank_select_bit0(ba0), .bank_select_bit1(ba1), .addr(addr), .write_mask(mask), .write_beat(beat));
    lpddr_cmd_bank lpddr_cmd_bank_i (.clk(clk), .rst(rst), .chip_sel_n(cs_n), .row_strobe_n(ras_n),
        .col_strobe_n(cas_n), .write_en_n(we_n), .clock_enable_now(cke), .bank_select_bit0(ba0),
        .bank_select_bit1(ba1), .addr(addr), .write_mask(mask), .write_beat(beat), .bank_state(bank_state),
        .col_addr(col_addr), .burst_bank(burst_bank), .auto_close_row(auto_close_row), .beat_store(beat_store),
        .mode_reg(mode_reg), .ext_mode_reg(ext_mode_reg), .status_reg_read(status_reg_read),
        .power_state(power_state), .exit_busy(exit_busy), .refresh_bank(refresh_bank),
        .refresh_pulse(refresh_pulse));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction : lfsr

    function automatic logic [ADDR_W-1:0] col_of(input logic ap);
        return {rnd[12:11], ap, rnd[9:0]};
    endfunction : col_of

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // one command per cycle, so back to back needs no gaps
    task automatic step(input cmd_e cc, input logic [1:0] bk, input logic [ADDR_W-1:0] a, input logic ck);
        @(posedge clk);
        req_cmd  <= cc;
        req_bank <= bk;
        req_addr <= a;
        req_cke  <= ck;
    endtask : step

    task automatic hold(input int n, input logic ck, input cmd_e cc);
        repeat (n) step(cc, 2'h0, '0, ck);
    endtask : hold

    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // clock, noise and watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // beats and masks are random every cycle, so masking is hit in some writes and not in others
    always @(posedge clk) begin
        rnd      <= lfsr(rnd);
        noise    <= rnd[ADDR_W-1:0];
        req_beat <= rnd[20];
        req_mask <= rnd[21];
    end

    initial begin
        #50000;
        errors++;
        finish_test();
    end

    // ------------------------------------------------------------
    // reference model, updated on the edge the design samples
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            m       = '0;
            m.pw    = PWR_ON;
            m.known = 1'b1;
            m.st    = {4{BANK_IDLE}};
        end else begin
            all_idle = (m.st == {4{BANK_IDLE}});
            nopish   = (req_cmd == CMD_NOP) || (req_cmd == CMD_DESEL);
            busy     = (m.cnt != 8'h00);
            ok       = req_cke && m.pcke && !busy && (m.pw == PWR_ON);
            m.pulse  = 1'b0;
            if (busy) m.cnt = m.cnt - 8'h01;
            if (m.pw == PWR_ON && m.pcke && !req_cke && !busy) begin
                if (nopish) m.pw = all_idle ? PWR_PRE_PD : PWR_ACT_PD;
                else if (req_cmd == CMD_REF && all_idle) m.pw = PWR_SELF;
                else if (req_cmd == CMD_BST && all_idle) m.pw = PWR_DEEP;
            end else if (m.pw != PWR_ON && !m.pcke && req_cke && nopish) begin
                m.cnt = (m.pw == PWR_SELF) ? 8'(SR_EXIT_CYC) : (m.pw == PWR_DEEP) ? 8'h00 : 8'(PD_EXIT_CYC);
                m.pw  = PWR_ON;
            end else if (ok) begin
                case (req_cmd)
                    CMD_ACT: if (m.st[req_bank] == BANK_IDLE) m.st[req_bank] = BANK_ACTIVE;
                    CMD_RD, CMD_WR: begin
                        if (m.st[req_bank] != BANK_IDLE) begin
                            m.st[req_bank] = req_addr[AP_BIT] ? BANK_IDLE :
                                             (req_cmd == CMD_RD) ? BANK_READ : BANK_WRITE;
                            m.col   = req_addr;
                            m.bb    = req_bank;
                            m.ap    = req_addr[AP_BIT];
                            m.known = 1'b1;
                        end else if (m.stat) m.known = 1'b0;
                        m.stat = 1'b0;
                    end
                    CMD_BST: if (m.st[m.bb] == BANK_READ) m.st[m.bb] = BANK_ACTIVE;
                    CMD_PRE: if (req_addr[AP_BIT]) m.st = {4{BANK_IDLE}}; else m.st[req_bank] = BANK_IDLE;
                    CMD_REF: if (all_idle) begin
                        m.rb    = m.rb + 2'h1;
                        m.pulse = 1'b1;
                    end
                    CMD_MRS: if (all_idle) begin
                        if (req_bank == MRS_TGT_MODE) m.mr = req_addr;
                        if (req_bank == MRS_TGT_EXT) m.emr = req_addr;
                        if (req_bank == MRS_TGT_STATUS) m.stat = 1'b1;
                    end
                    default: ;
                endcase
            end
            m.pcke = req_cke;
        end
    end

    // compare mid-cycle, where registers and the beat path have settled
    always @(negedge clk) begin
        if (!rst) begin
            check("bank state", bank_state, m.st);
            check("mode reg", mode_reg, m.mr);
            check("ext mode reg", ext_mode_reg, m.emr);
            check("status read", status_reg_read, m.stat);
            check("power", power_state, m.pw);
            check("exit busy", exit_busy, m.cnt != 8'h00);
            check("refresh bank", refresh_bank, m.rb);
            check("refresh pulse", refresh_pulse, m.pulse);
            if (m.known) begin
                check("column", col_addr, m.col);
                check("burst bank", burst_bank, m.bb);
                check("auto close", auto_close_row, m.ap);
                check("beat", beat_store, req_beat && !req_mask && m.st[m.bb] == BANK_WRITE);
            end
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst      = 1'b1;
        rnd      = 32'h0001435f;
        noise    = '0;
        req_beat = 1'b0;
        req_mask = 1'b0;
        req_cmd  = CMD_NOP;
        req_bank = '0;
        req_addr = '0;
        req_cke  = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        hold(3, 1'b1, CMD_NOP);
        // every set target, then status read
        step(CMD_MRS, MRS_TGT_MODE, rnd[12:0], 1'b1);
        step(CMD_MRS, MRS_TGT_EXT, rnd[25:13], 1'b1);
        step(CMD_MRS, MRS_TGT_STATUS, '0, 1'b1);
        step(CMD_RD, rnd[1:0], rnd[12:0], 1'b1);
        for (int i = 0; i < 4; i++) step(CMD_ACT, 2'(i), rnd[12:0], 1'b1);
        // truncations back to back on bank one
        step(CMD_RD, 2'h1, col_of(1'b0), 1'b1);
        step(CMD_RD, 2'h1, col_of(1'b0), 1'b1);
        step(CMD_BST, 2'h0, '0, 1'b1);
        step(CMD_WR, 2'h1, col_of(1'b0), 1'b1);
        step(CMD_WR, 2'h1, col_of(1'b0), 1'b1);
        // beats after the cutting read are not stored
        step(CMD_RD, 2'h1, col_of(1'b0), 1'b1);
        step(CMD_BST, 2'h0, '0, 1'b1);
        step(CMD_WR, 2'h1, col_of(1'b0), 1'b1);
        // single bank precharge, then on an idle bank
        step(CMD_PRE, 2'h1, col_of(1'b0), 1'b1);
        step(CMD_PRE, 2'h1, col_of(1'b0), 1'b1);
        step(CMD_RD, 2'h2, col_of(1'b1), 1'b1);
        step(CMD_WR, 2'h3, col_of(1'b0), 1'b1);
        step(CMD_PRE, rnd[1:0], col_of(1'b1), 1'b1);
        // refresh from all idle with junk address
        hold(2, 1'b1, CMD_REF);
        step(CMD_ACT, 2'h2, '0, 1'b1);
        hold(4, 1'b0, CMD_DESEL);
        hold(4, 1'b1, CMD_NOP);
        step(CMD_PRE, 2'h0, col_of(1'b1), 1'b1);
        hold(3, 1'b0, CMD_NOP);
        hold(4, 1'b1, CMD_DESEL);
        step(CMD_REF, 2'h0, '0, 1'b0);
        hold(4, 1'b0, CMD_DESEL);
        hold(SR_EXIT_CYC + 2, 1'b1, CMD_NOP);
        step(CMD_BST, 2'h0, '0, 1'b0);
        hold(3, 1'b0, CMD_NOP);
        hold(3, 1'b1, CMD_NOP);
        repeat (300) begin
            #1;
            c = pick[rnd[2:0]];
            b = rnd[4:3];
            // auto close bursts idle at once, then only activate follows
            if ((c == CMD_RD || c == CMD_WR) && m.st[b] == BANK_IDLE) c = CMD_ACT;
            if (c == CMD_ACT && m.st[b] != BANK_IDLE) c = CMD_NOP;
            // a write to a reading bank ends the read first
            if (c == CMD_WR && m.st[b] == BANK_READ) c = CMD_BST;
            if (c == CMD_BST && !(m.known && m.st[m.bb] == BANK_READ)) c = CMD_NOP;
            step(c, b, col_of(rnd[5]), 1'b1);
            // a nop after each pick, so the next pick sees settled state
            step(CMD_NOP, 2'h0, '0, 1'b1);
        end
        hold(2, 1'b1, CMD_NOP);
        finish_test();
    end
endmodule : lpddr_command_decode_and_bank_state_tb

// >>> verification/lpddr_host_model.sv
// host controller model: puts requested commands onto the memory pins
// assumes requests change just after a rising clk edge; noise is fresh each cycle
`timescale 1ns/1ps
module lpddr_host_model
    import lpddr_cmd_pkg::*;
(
    // requests from the bench
    input  wire cmd_e              req_cmd,
    input  wire logic [BANK_W-1:0] req_bank,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic              req_cke,
    input  wire logic              req_mask,
    input  wire logic              req_beat,
    input  wire logic [ADDR_W-1:0] noise,
    // memory pins
    output logic                   chip_sel_n,
    output logic                   row_strobe_n,
    output logic                   col_strobe_n,
    output logic                   write_en_n,
    output logic                   clock_enable_now,
    output logic                   bank_select_bit0,
    output logic                   bank_select_bit1,
    output logic [ADDR_W-1:0]      addr,
    output logic                   write_mask,
    output logic                   write_beat
);
    // ------------------------------------------------------------
    // command encoding
    // ------------------------------------------------------------
    logic [3:0] pins;
    logic       addressed;

    always_comb begin
        addressed = 1'b1;
        case (req_cmd)
            CMD_ACT: pins = 4'h3;
            CMD_RD:  pins = 4'h5;
            CMD_WR:  pins = 4'h4;
            CMD_PRE: pins = 4'h2;
            CMD_MRS: pins = 4'h0;
            CMD_REF: begin
                pins      = 4'h1;
                addressed = 1'b0;
            end
            CMD_BST: begin
                pins      = 4'h6;
                addressed = 1'b0;
            end
            CMD_DESEL: begin
                pins      = {1'b1, noise[4:2]};
                addressed = 1'b0;
            end
            default: begin
                pins      = 4'h7;
                addressed = 1'b0;
            end
        endcase
    end

    // unused fields are refilled from noise every cycle, so a stale latch shows up
    assign {chip_sel_n, row_strobe_n, col_strobe_n, write_en_n} = pins;
    assign {bank_select_bit1, bank_select_bit0} = addressed ? req_bank : noise[6:5];
    assign addr = addressed ? req_addr : noise;
    assign write_mask = req_mask;
    assign write_beat = req_beat;
    // cke low only for low power entry and hold
    assign clock_enable_now = req_cke;
endmodule : lpddr_host_model
